/* hw/par_port.sv */
/*
 Sixteen-bit parallel handshake port: separate in and out data paths,
 request/ready handshake in pulse or full mode, direction line, special
 lines and external interrupt. Control and status bits are plain ports.
 Assumes the host raises start_xfer for one cycle; xfer_dir is sampled only with it.
*/
`timescale 1ns/1ps
module par_port #(
   parameter int unsigned DATA_W    = par_port_pkg::DATA_W,
   parameter bit          DOUT_CLR  = 1'b1
) (
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              start_xfer,
   input  wire logic              xfer_dir_in,
   input  wire logic [DATA_W-1:0] host_wdata,
   input  wire logic              full_mode,
   input  wire logic              positive_logic,
   input  wire logic              flag_valid_high,
   input  wire logic              irq_enable,
   input  wire logic              irq_clear,
   input  wire logic [1:0]        host_special_out,
   output logic      [DATA_W-1:0] host_rdata,
   output logic                   xfer_done,
   output logic      [3:0]        term_reason,
   output logic                   busy,
   output logic                   host_irq,
   output logic      [1:0]        host_special_in,
   output logic                   peripheral_status_seen,
   input  wire logic [DATA_W-1:0] pin_data_in,
   output logic      [DATA_W-1:0] pin_data_out,
   output logic                   transfer_request_line,
   input  wire logic              peripheral_ready_line,
   input  wire logic              peripheral_status_line,
   input  wire logic              external_interrupt_request,
   output logic                   direction_line,
   output logic                   transfer_control_state,
   output logic                   peripheral_reset_n,
   input  wire logic [1:0]        periph_special_in,
   output logic      [1:0]        periph_special_out
);
   if (DATA_W != par_port_pkg::DATA_W) begin : gen_bad_width
      $error("par_port data width must be 16");
   end

   localparam logic [7:0] RST_CYC = 8'(par_port_pkg::RESET_PULSE_CYC);
   localparam logic [7:0] REQ_CYC = 8'(par_port_pkg::REQ_PULSE_CYC);

   logic [4:0] sync_out;
   logic       ready_s;
   logic       status_s;
   logic       eir_s;
   logic       flag_valid;
   logic       eir_prev_reg;
   logic       eir_rise;

   bit_sync #(
      .WIDTH  (5),
      .STAGES (par_port_pkg::SYNC_STAGES)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in ({periph_special_in, external_interrupt_request,
                  peripheral_status_line, peripheral_ready_line}),
      .sync_out (sync_out)
   );

   assign ready_s  = sync_out[0];
   assign status_s = sync_out[1];
   assign eir_s    = sync_out[2];
   assign flag_valid = (ready_s == flag_valid_high);
   assign eir_rise = eir_s & ~eir_prev_reg;

   par_port_pkg::port_state_t state_reg;
   logic [7:0]                cnt_reg;
   logic                      dir_reg;
   logic [DATA_W-1:0]         dout_reg;
   logic [DATA_W-1:0]         rdata_reg;
   logic                      req_reg;
   logic                      done_reg;
   logic [3:0]                term_reg;
   logic                      ctl_reg;
   logic                      prst_reg;
   logic                      irq_reg;
   logic                      sts_reg;
   logic [1:0]                sp_in_reg;
   logic [1:0]                sp_out_reg;

   // Sequencing uses only request, handshake mode, ready flag and external interrupt; direction does not steer it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= par_port_pkg::ST_RESET;
         cnt_reg   <= RST_CYC;
         req_reg   <= 1'b0;
         dir_reg   <= 1'b0;
         done_reg  <= 1'b0;
         term_reg  <= par_port_pkg::TERM_NONE;
         sts_reg   <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         unique case (state_reg)
            par_port_pkg::ST_RESET: begin
               // Request held low for the reset pulse, then stays low while idle
               if (cnt_reg == 8'h01) begin
                  state_reg <= par_port_pkg::ST_IDLE;
               end
               cnt_reg <= cnt_reg - 8'h01;
            end
            par_port_pkg::ST_IDLE: begin
               if (start_xfer) begin
                  dir_reg   <= xfer_dir_in;
                  sts_reg   <= status_s;
                  req_reg   <= 1'b1;
                  cnt_reg   <= REQ_CYC;
                  state_reg <= par_port_pkg::ST_REQ;
               end
            end
            par_port_pkg::ST_REQ: begin
               // Pulse mode drops request after a fixed width
               if (!full_mode && cnt_reg != 8'h01) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else if (!full_mode) begin
                  req_reg   <= 1'b0;
                  state_reg <= par_port_pkg::ST_WAIT_DONE;
               end else if (!flag_valid) begin
                  state_reg <= par_port_pkg::ST_WAIT_BUSY;
               end
            end
            par_port_pkg::ST_WAIT_BUSY: begin
               if (flag_valid) begin
                  req_reg   <= 1'b0;
                  state_reg <= par_port_pkg::ST_WAIT_DONE;
               end
            end
            par_port_pkg::ST_WAIT_DONE: begin
               if (flag_valid) begin
                  done_reg  <= 1'b1;
                  term_reg  <= par_port_pkg::TERM_DONE;
                  state_reg <= par_port_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= par_port_pkg::ST_IDLE;
            end
         endcase
         // Interrupt aborts an active transfer
         if (eir_rise && state_reg != par_port_pkg::ST_IDLE
             && state_reg != par_port_pkg::ST_RESET) begin
            req_reg   <= 1'b0;
            done_reg  <= 1'b1;
            term_reg  <= par_port_pkg::TERM_STATUS;
            state_reg <= par_port_pkg::ST_IDLE;
         end
      end
   end

   // Output data latched at start, so it cannot move under the request
   always_ff @(posedge core_clk) begin
      if (reset) begin
         if (DOUT_CLR) begin
            dout_reg <= par_port_pkg::DOUT_CLEAR_VAL;
         end
      end else if (state_reg == par_port_pkg::ST_IDLE && start_xfer && !xfer_dir_in) begin
         dout_reg <= host_wdata;
      end
   end

   // Capture on valid flag while an input transfer waits
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_reg <= '0;
      end else if (dir_reg && flag_valid
                   && state_reg == par_port_pkg::ST_WAIT_DONE) begin
         rdata_reg <= positive_logic ? pin_data_in : ~pin_data_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctl_reg      <= 1'b0;
         prst_reg     <= 1'b1;
         irq_reg      <= 1'b0;
         eir_prev_reg <= 1'b0;
         sp_in_reg    <= 2'h0;
         sp_out_reg   <= 2'h0;
      end else begin
         ctl_reg      <= 1'b0;
         prst_reg     <= (state_reg == par_port_pkg::ST_RESET);
         eir_prev_reg <= eir_s;
         sp_in_reg    <= sync_out[4:3];
         sp_out_reg   <= host_special_out;
         // Set wins over clear
         if (irq_enable && eir_s) begin
            irq_reg <= 1'b1;
         end else if (irq_clear) begin
            irq_reg <= 1'b0;
         end
      end
   end

   // After reset, negative-logic data out is all ones
   assign pin_data_out = positive_logic ? dout_reg : ~dout_reg;
   assign host_rdata             = rdata_reg;
   assign xfer_done              = done_reg;
   assign term_reason            = term_reg;
   assign busy                   = state_reg != par_port_pkg::ST_IDLE;
   assign host_irq               = irq_reg;
   assign host_special_in        = sp_in_reg;
   assign peripheral_status_seen = sts_reg;
   assign transfer_request_line  = req_reg;
   assign direction_line         = dir_reg;
   assign transfer_control_state = ctl_reg;
   assign peripheral_reset_n     = ~prst_reg;
   assign periph_special_out     = sp_out_reg;
endmodule

/* hw/par_port_pkg.sv */
/*
 Constants and types for the 16-bit parallel handshake port.
 Assumes a single 100 MHz core clock and synchronous active-high reset.
*/
package par_port_pkg;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned SPECIAL_W       = 2;
   localparam int unsigned SYNC_STAGES     = 2;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   // Width of the reset pulses on the request and peripheral reset lines
   localparam int unsigned RESET_PULSE_NS  = 100;
   localparam int unsigned RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Pulse-mode request width
   localparam int unsigned REQ_PULSE_NS    = 50;
   localparam int unsigned REQ_PULSE_CYC   =
      (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] DOUT_CLEAR_VAL  = 16'h0000;
   localparam logic [3:0]  TERM_NONE       = 4'h0;
   localparam logic [3:0]  TERM_DONE       = 4'h1;
   localparam logic [3:0]  TERM_STATUS     = 4'h4;

   typedef enum logic {
      HS_PULSE,
      HS_FULL
   } hs_mode_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_IDLE,
      ST_REQ,
      ST_WAIT_BUSY,
      ST_WAIT_DONE
   } port_state_t;
endpackage

/* hw/bit_sync.sv */
/*
 Two-or-more flop level synchroniser, one lane per bit.
 Assumes inputs are plain levels that change slower than the clock.
*/
`timescale 1ns/1ps
module bit_sync #(
   parameter int unsigned WIDTH  = 1,
   parameter int unsigned STAGES = 2
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // Refused at elaboration: one flop alone would not settle metastability
   if (STAGES < 2) begin : gen_bad_stages
      $error("bit_sync needs at least two stages");
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : lane
         logic [STAGES-1:0] chain_reg;
         // First stage is read only by the next stage
         always_ff @(posedge core_clk) begin
            if (reset) begin
               chain_reg <= '0;
            end else begin
               chain_reg <= {chain_reg[STAGES-2:0], async_in[g]};
            end
         end
         assign sync_out[g] = chain_reg[STAGES-1];
      end
   endgenerate
endmodule

/* tb/par_port_chk.sv */
/* Assertions on the parallel port handshake and reset behaviour.
   Bound to par_port; one core clock, synchronous active-high reset. */
`timescale 1ns/1ps
module par_port_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        start_xfer,
   input wire logic        xfer_dir_in,
   input wire logic        full_mode,
   input wire logic        positive_logic,
   input wire logic        xfer_done,
   input wire logic [3:0]  term_reason,
   input wire logic        busy,
   input wire logic [15:0] pin_data_out,
   input wire logic        transfer_request_line,
   input wire logic        external_interrupt_request,
   input wire logic        direction_line,
   input wire logic        transfer_control_state,
   input wire logic        peripheral_reset_n
);
   default clocking cb @(posedge core_clk); endclocking
   sequence req_pulse_s;
      transfer_request_line [*5] ##1 !transfer_request_line;
   endsequence
   sequence abort_s;
      xfer_done && term_reason == par_port_pkg::TERM_STATUS;
   endsequence
   out_stable_a: assert property (disable iff (reset)
      transfer_request_line && $past(transfer_request_line) |-> $stable(pin_data_out))
      else $error("data out moved under request");
   out_clear_a: assert property (
      reset |=> pin_data_out == (par_port_pkg::DOUT_CLEAR_VAL ^ {16{!positive_logic}}))
      else $error("data out not cleared by reset");
   reset_lines_a: assert property (
      $fell(reset) |-> (!transfer_request_line && !peripheral_reset_n) [*8])
      else $error("reset pulses missing");
   ctl_clear_a: assert property (disable iff (reset) !transfer_control_state)
      else $error("control state not clear");
   start_req_a: assert property (disable iff (reset)
      !busy && start_xfer |=> transfer_request_line && busy
         && direction_line == $past(xfer_dir_in))
      else $error("start not answered by request");
   pulse_width_a: assert property (disable iff (reset)
      $rose(transfer_request_line) && !full_mode |-> req_pulse_s)
      else $error("pulse request width wrong");
   eir_abort_a: assert property (disable iff (reset)
      busy && $rose(external_interrupt_request) |-> ##[2:6] abort_s)
      else $error("interrupt did not end transfer");
   done_pulse_a: assert property (disable iff (reset) xfer_done |=> !xfer_done)
      else $error("done longer than one cycle");
endmodule
bind par_port par_port_chk u_chk (
   .core_clk, .reset, .start_xfer, .xfer_dir_in, .full_mode, .positive_logic, .xfer_done,
   .term_reason, .busy, .pin_data_out, .transfer_request_line, .external_interrupt_request,
   .direction_line, .transfer_control_state, .peripheral_reset_n
);

/* tb/par_periph_model.sv */
/* Behavioural peripheral on the far side of the port pins.
   Assumes the bench supplies the word to offer and the response delay. */
`timescale 1ns/1ps
module par_periph_model (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        transfer_request_line,
   input  wire logic        flag_valid_high,
   input  wire logic [15:0] pin_data_out,
   input  wire logic [15:0] word,
   input  wire logic [7:0]  delay,
   output logic             peripheral_ready_line,
   output logic [15:0]      pin_data_in,
   output logic [15:0]      seen_word
);
   logic       req_reg, valid_reg;
   logic [7:0] cnt_reg, hold_reg;
   always_ff @(posedge core_clk) begin
      req_reg <= transfer_request_line;
      if (reset) begin
         valid_reg <= 1'b1;
         cnt_reg   <= 8'h00;
         hold_reg  <= 8'h00;
      end else if (transfer_request_line && !req_reg) begin
         valid_reg <= 1'b0;
         cnt_reg   <= delay;
      end else if (!valid_reg) begin
         valid_reg <= (cnt_reg == 8'h00);
         cnt_reg   <= cnt_reg - 8'h01;
         hold_reg  <= 8'h06;
      end else if (hold_reg != 8'h00) begin
         hold_reg <= hold_reg - 8'h01;
      end
   end
   always_ff @(posedge core_clk) begin
      if (transfer_request_line) begin
         seen_word <= pin_data_out;
      end
   end
   assign peripheral_ready_line = valid_reg ? flag_valid_high : !flag_valid_high;
   // Inverse once the hold runs out, so a late capture cannot pass
   assign pin_data_in = (!valid_reg || hold_reg != 8'h00) ? word : ~word;
endmodule

/* tb/tb_top.sv */
/* Self-checking bench for the parallel port against a peripheral model.
   Assumes the default data-out clear option and a 100 MHz core clock. */
`timescale 1ns/1ps
module tb_top;
   logic        core_clk = 1'b0, reset = 1'b1, start_xfer = 1'b0, xfer_dir_in = 1'b0;
   logic        full_mode = 1'b0, positive_logic = 1'b0, flag_valid_high = 1'b0;
   logic        irq_enable = 1'b0, irq_clear = 1'b0, peripheral_status_line = 1'b0;
   logic        external_interrupt_request = 1'b0, peripheral_ready_line, xfer_done;
   logic        busy, host_irq, peripheral_status_seen, transfer_request_line;
   logic        direction_line, transfer_control_state, peripheral_reset_n;
   logic [1:0]  host_special_out = 2'h0, periph_special_in = 2'h0;
   logic [1:0]  host_special_in, periph_special_out;
   logic [3:0]  term_reason;
   logic [7:0]  p_dly = 8'h01, eir_at = 8'hff;
   logic [15:0] host_wdata = 16'h0000, p_word = 16'h0000, host_rdata, pin_data_in;
   logic [15:0] pin_data_out, seen_word;
   int          fails = 0, cmp_count = 0;
   // Mode nibble: full, positive, flag high, input; then delay, word, expected
   logic [43:0] r;
   logic [43:0] rows [8] = '{44'h0_01_a5c3_5a3c, 44'h6_09_a5c3_a5c3, 44'ha_03_0001_fffe,
      44'hc_0c_8000_8000, 44'h3_02_1234_edcb, 44'h5_07_ffff_ffff, 44'h9_01_0f0f_f0f0,
      44'hf_0a_0000_0000};
   always #5 core_clk = ~core_clk;
   par_port u_dut (
      .core_clk, .reset, .start_xfer, .xfer_dir_in, .host_wdata, .full_mode, .positive_logic,
      .flag_valid_high, .irq_enable, .irq_clear, .host_special_out, .host_rdata, .xfer_done,
      .term_reason, .busy, .host_irq, .host_special_in, .peripheral_status_seen, .pin_data_in,
      .pin_data_out, .transfer_request_line, .peripheral_ready_line, .peripheral_status_line,
      .external_interrupt_request, .direction_line, .transfer_control_state,
      .peripheral_reset_n, .periph_special_in, .periph_special_out
   );
   par_periph_model u_periph (
      .core_clk, .reset, .transfer_request_line, .flag_valid_high, .pin_data_out,
      .word(p_word), .delay(p_dly), .peripheral_ready_line, .pin_data_in, .seen_word
   );
   task automatic test_done;
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v, input string nm);
      cmp_count++;
      if (seen_v !== exp_v) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask
   task automatic xfer(input logic d, input logic [15:0] w, input logic [3:0] term);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk(16'(busy), 16'h0000, "idle_wait");
      start_xfer  <= 1'b1;
      xfer_dir_in <= d;
      host_wdata  <= w;
      @(posedge core_clk);
      start_xfer <= 1'b0;
      @(posedge core_clk);
      chk(16'({transfer_request_line, direction_line}), 16'({1'b1, d}), "req_dir");
      n = 0;
      while (xfer_done !== 1'b1 && n < 200) begin
         if (n == eir_at) begin
            external_interrupt_request <= 1'b1;
            peripheral_status_line     <= 1'b0;
         end
         @(posedge core_clk);
         n++;
      end
      chk(16'(xfer_done), 16'h0001, "xfer_done");
      chk(16'(term_reason), 16'(term), "term_reason");
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      chk(pin_data_out, ~par_port_pkg::DOUT_CLEAR_VAL, "data_clear");
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'({busy, peripheral_reset_n, transfer_request_line, transfer_control_state}),
         16'h0008, "reset_lines");
      foreach (rows[i]) begin
         r = rows[i];
         full_mode       <= r[43];
         positive_logic  <= r[42];
         flag_valid_high <= r[41];
         p_dly           <= r[39:32];
         p_word          <= r[31:16];
         repeat (4) @(posedge core_clk);
         xfer(r[40], r[31:16], par_port_pkg::TERM_DONE);
         chk(r[40] ? host_rdata : seen_word, r[15:0], "data_word");
         chk(16'(peripheral_status_seen), 16'h0000, "status_idle");
      end
      host_special_out  <= 2'h2;
      periph_special_in <= 2'h1;
      repeat (5) @(posedge core_clk);
      chk(16'({host_special_in, periph_special_out}), 16'h0006, "special");
      irq_enable             <= 1'b1;
      peripheral_status_line <= 1'b1;
      p_dly                  <= 8'h28;
      eir_at                 <= 8'h04;
      repeat (4) @(posedge core_clk);
      xfer(1'b0, 16'h3c5a, par_port_pkg::TERM_STATUS);
      chk(16'(peripheral_status_seen), 16'h0001, "status_seen");
      external_interrupt_request <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'(host_irq), 16'h0001, "irq_set");
      irq_clear <= 1'b1;
      @(posedge core_clk);
      irq_clear <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'(host_irq), 16'h0000, "irq_clear");
      // Masked interrupt must not reach the host
      irq_enable                 <= 1'b0;
      external_interrupt_request <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(16'(host_irq), 16'h0000, "irq_masked");
      external_interrupt_request <= 1'b0;
      repeat (3) @(posedge core_clk);
      // Reset in the middle of an output transfer
      start_xfer <= 1'b1;
      @(posedge core_clk);
      start_xfer <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'({busy, peripheral_reset_n, transfer_request_line}), 16'h0004, "mid_reset");
      chk(pin_data_out, par_port_pkg::DOUT_CLEAR_VAL, "mid_clear");
      repeat (12) @(posedge core_clk);
      chk(16'({busy, peripheral_reset_n}), 16'h0001, "reset_end");
      test_done;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      test_done;
   end
endmodule
